/* inc/cci_consts.vh */
// Constants for the calibration command interpreter
`ifndef CCI_CONSTS_VH
`define CCI_CONSTS_VH
// Command codes on cmd_code
`define CCI_CMD_FACTORY_RESTORE 4'h1
`define CCI_CMD_STORE_CONFIG 4'h2
`define CCI_CMD_CALIBRATE_NOW 4'h3
`define CCI_CMD_CTRL_WRITE 4'h4
`define CCI_CMD_CTRL_READ 4'h5
`define CCI_CMD_RESTART 4'h6
`define CCI_CMD_PARAM_WRITE 4'h7
`define CCI_CMD_MEAS_READ 4'h8
`define CCI_CMD_STATUS_READ 4'h9
// Reply codes on rsp_code
`define CCI_RSP_NONE 4'h0
`define CCI_RSP_BANNER 4'h1
`define CCI_RSP_OK 4'h2
`define CCI_RSP_CTRL 4'h3
`define CCI_RSP_UNKNOWN 4'h4
`define CCI_RSP_VALUE_LIMIT 4'h5
`define CCI_RSP_CHANNEL_OFF 4'h6
`define CCI_RSP_UNDERFLOW 4'h7
`define CCI_RSP_OVERFLOW 4'h8
`define CCI_RSP_VALUE 4'h9
`define CCI_RSP_STATUS 4'hA
// Control byte fields and reset value
`define CCI_CTRL_MANUAL_BIT 0
`define CCI_CTRL_START_BIT 1
`define CCI_CTRL_RESET 8'h00
// Status byte field
`define CCI_STAT_CAL_BIT 0
// Timing, clock 10 MHz
`define CCI_CLK_HZ 10000000
`define CCI_EARLY_MIN 15
`define CCI_LATE_MIN 60
`define CCI_EARLY_RUNS 4
`define CCI_BANNER_MAX_MS 5000
`endif

/* rtl/cci_timer.v */
// Minute tick generator for automatic calibration scheduling
module cci_timer #(
    parameter CYC_PER_MIN = 600000000
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Restart of the count
    input wire clear,
    // Minute tick
    output reg tick_q
);
    reg [31:0] cnt_q;

    always @(posedge clk)
    begin
        if (!rst_n || clear)
        begin
            cnt_q <= 32'h0;
            tick_q <= 1'b0;
        end
        else if (cnt_q == CYC_PER_MIN - 1)
        begin
            cnt_q <= 32'h0;
            tick_q <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 32'h1;
            tick_q <= 1'b0;
        end
    end
endmodule

/* rtl/cci_core.v */
// Calibration command interpreter core
//
// Behaviour
// - Factory restore keeps range, restarts, sends banner
// - Save writes config to storage, replies OK
// - Auto calibration every 15 min, then hourly
// - Manual bit set stops automatic calibration
// - Start bit rising edge starts calibration
// - Control write/read reply with control byte
// - Banner with release after every reset
// - Banner within five seconds of reset
// - Unknown command gives unknown-command error
// - Out-of-limit parameter gives value-limit error
// - Switched-off channel read gives channel error
// - Below range measurement gives underflow error
// - Above range measurement gives overflow error
// - Status bit 0 set while calibrating
// - Out-of-range measurement answered with error
`include "cci_consts.vh"
module cci_core #(
    parameter CYC_PER_MIN = 600000000,
    parameter BANNER_DELAY = 1000,
    parameter CAL_CYCLES = 1000,
    parameter RANGE_W = 4,
    parameter VALUE_W = 16,
    parameter RELEASE = 8'h10
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Command in
    input wire cmd_valid,
    input wire [3:0] cmd_code,
    input wire [7:0] cmd_data,
    // Parameter write check
    input wire [VALUE_W-1:0] param_value,
    input wire [VALUE_W-1:0] param_min,
    input wire [VALUE_W-1:0] param_max,
    input wire param_is_upper,
    input wire [VALUE_W-1:0] param_pair_lower,
    // Measurement read inputs
    input wire [1:0] meas_channel,
    input wire [2:0] channel_on,
    input wire [VALUE_W-1:0] meas_value,
    input wire [VALUE_W-1:0] meas_lo,
    input wire [VALUE_W-1:0] meas_hi,
    // Configuration storage
    input wire [RANGE_W-1:0] work_range,
    input wire store_done,
    // Reply out
    output reg rsp_valid_q,
    output reg [3:0] rsp_code_q,
    output reg [VALUE_W-1:0] rsp_data_q,
    // Actions
    output reg load_defaults_q,
    output reg [RANGE_W-1:0] keep_range_q,
    output reg store_start_q,
    output reg cal_busy_q,
    output reg [7:0] ctrl_q
);
    localparam S_BOOT = 2'h0;
    localparam S_IDLE = 2'h1;
    localparam S_STORE = 2'h2;

    reg [1:0] state_q;
    reg [31:0] wait_q;
    reg [31:0] cal_cnt_q;
    reg start_prev_q;
    reg [5:0] min_q;
    reg [2:0] early_q;
    reg soft_rst_q;
    wire tick;
    reg cal_req;
    reg auto_due;

    function out_of_range;
        input [VALUE_W-1:0] v;
        input [VALUE_W-1:0] lo;
        input [VALUE_W-1:0] hi;
        begin
            out_of_range = (v < lo) || (v > hi);
        end
    endfunction

    ////////////////////////////////////////////////////////////////
    // Minute ticks
    cci_timer #(
        .CYC_PER_MIN(CYC_PER_MIN)
    ) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .clear(soft_rst_q),
        .tick_q(tick)
    );

    always @*
    begin
        auto_due = 1'b0;
        if (tick && !ctrl_q[`CCI_CTRL_MANUAL_BIT])
        begin
            if (early_q < `CCI_EARLY_RUNS)
                auto_due = (min_q == `CCI_EARLY_MIN - 1);
            else
                auto_due = (min_q == `CCI_LATE_MIN - 1);
        end
    end

    ////////////////////////////////////////////////////////////////
    // Calibration scheduling and run
    always @(posedge clk)
    begin
        if (!rst_n || soft_rst_q)
        begin
            min_q <= 6'h00;
            early_q <= 3'h0;
            cal_busy_q <= 1'b0;
            cal_cnt_q <= 32'h0;
            // Soft reset keeps the control byte, so track it to avoid a false edge
            start_prev_q <= rst_n && ctrl_q[`CCI_CTRL_START_BIT];
        end
        else
        begin
            start_prev_q <= ctrl_q[`CCI_CTRL_START_BIT];
            if (tick)
            begin
                if (auto_due || (min_q == `CCI_LATE_MIN - 1))
                begin
                    min_q <= 6'h00;
                    if (early_q < `CCI_EARLY_RUNS)
                        early_q <= early_q + 3'h1;
                end
                else
                    min_q <= min_q + 6'h01;
            end
            if (cal_req || auto_due)
            begin
                cal_busy_q <= 1'b1;
                cal_cnt_q <= 32'h0;
            end
            else if (cal_busy_q)
            begin
                if (cal_cnt_q == CAL_CYCLES - 1)
                    cal_busy_q <= 1'b0;
                else
                    cal_cnt_q <= cal_cnt_q + 32'h1;
            end
        end
    end

    always @*
    begin
        // Edge only, a steady one does not retrigger
        cal_req = ctrl_q[`CCI_CTRL_START_BIT] && !start_prev_q;
        if (state_q == S_IDLE && cmd_valid && cmd_code == `CCI_CMD_CALIBRATE_NOW)
            cal_req = 1'b1;
    end

    ////////////////////////////////////////////////////////////////
    // Command decode and replies
    always @(posedge clk)
    begin
        if (!rst_n || soft_rst_q)
        begin
            state_q <= S_BOOT;
            wait_q <= 32'h0;
            rsp_valid_q <= 1'b0;
            rsp_code_q <= `CCI_RSP_NONE;
            rsp_data_q <= {VALUE_W{1'b0}};
            store_start_q <= 1'b0;
            soft_rst_q <= 1'b0;
            load_defaults_q <= 1'b0;
            if (!rst_n)
            begin
                ctrl_q <= `CCI_CTRL_RESET;
                keep_range_q <= {RANGE_W{1'b0}};
            end
        end
        else
        begin
            rsp_valid_q <= 1'b0;
            store_start_q <= 1'b0;
            load_defaults_q <= 1'b0;
            case (state_q)
                S_BOOT:
                begin
                    if (wait_q == BANNER_DELAY - 1)
                    begin
                        rsp_valid_q <= 1'b1;
                        rsp_code_q <= `CCI_RSP_BANNER;
                        rsp_data_q <= {{(VALUE_W-8){1'b0}}, RELEASE[7:0]};
                        state_q <= S_IDLE;
                    end
                    else
                        wait_q <= wait_q + 32'h1;
                end
                S_STORE:
                begin
                    if (store_done)
                    begin
                        rsp_valid_q <= 1'b1;
                        rsp_code_q <= `CCI_RSP_OK;
                        state_q <= S_IDLE;
                    end
                end
                S_IDLE:
                begin
                    if (cmd_valid)
                    begin
                        rsp_valid_q <= 1'b1;
                        rsp_data_q <= {VALUE_W{1'b0}};
                        case (cmd_code)
                            `CCI_CMD_FACTORY_RESTORE:
                            begin
                                rsp_valid_q <= 1'b0;
                                load_defaults_q <= 1'b1;
                                keep_range_q <= work_range;
                                soft_rst_q <= 1'b1;
                            end
                            `CCI_CMD_RESTART:
                            begin
                                rsp_valid_q <= 1'b0;
                                soft_rst_q <= 1'b1;
                            end
                            `CCI_CMD_STORE_CONFIG:
                            begin
                                rsp_valid_q <= 1'b0;
                                store_start_q <= 1'b1;
                                state_q <= S_STORE;
                            end
                            `CCI_CMD_CALIBRATE_NOW:
                                rsp_code_q <= `CCI_RSP_OK;
                            `CCI_CMD_CTRL_WRITE:
                            begin
                                ctrl_q <= cmd_data;
                                rsp_code_q <= `CCI_RSP_CTRL;
                                rsp_data_q <= {{(VALUE_W-8){1'b0}}, cmd_data};
                            end
                            `CCI_CMD_CTRL_READ:
                            begin
                                rsp_code_q <= `CCI_RSP_CTRL;
                                rsp_data_q <= {{(VALUE_W-8){1'b0}}, ctrl_q};
                            end
                            `CCI_CMD_STATUS_READ:
                            begin
                                rsp_code_q <= `CCI_RSP_STATUS;
                                rsp_data_q <= {{(VALUE_W-1){1'b0}}, cal_busy_q};
                            end
                            `CCI_CMD_PARAM_WRITE:
                            begin
                                if (out_of_range(param_value, param_min, param_max) ||
                                    (param_is_upper && param_value <= param_pair_lower))
                                    rsp_code_q <= `CCI_RSP_VALUE_LIMIT;
                                else
                                    rsp_code_q <= `CCI_RSP_OK;
                            end
                            `CCI_CMD_MEAS_READ:
                            begin
                                if (meas_channel > 2'h2 || !channel_on[meas_channel])
                                    rsp_code_q <= `CCI_RSP_CHANNEL_OFF;
                                else if (meas_value < meas_lo)
                                    rsp_code_q <= `CCI_RSP_UNDERFLOW;
                                else if (meas_value > meas_hi)
                                    rsp_code_q <= `CCI_RSP_OVERFLOW;
                                else
                                begin
                                    rsp_code_q <= `CCI_RSP_VALUE;
                                    rsp_data_q <= meas_value;
                                end
                            end
                            default:
                                rsp_code_q <= `CCI_RSP_UNKNOWN;
                        endcase
                    end
                end
                default:
                    state_q <= S_IDLE;
            endcase
        end
    end
endmodule

/* verif/cci_props.sv */
// Port assertions for the calibration command interpreter
`include "cci_consts.vh"
module cci_props #(
    parameter VALUE_W = 16
) (
    // Clock, reset and command
    input logic clk,
    input logic rst_n,
    input logic cmd_valid,
    input logic [3:0] cmd_code,
    // Replies and actions
    input logic rsp_valid_q,
    input logic [3:0] rsp_code_q,
    input logic [VALUE_W-1:0] rsp_data_q,
    input logic load_defaults_q,
    input logic store_start_q,
    input logic cal_busy_q,
    input logic [7:0] ctrl_q
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    a_calnow_busy: assert property (
        $past(cmd_valid) && $past(cmd_code) == `CCI_CMD_CALIBRATE_NOW && rsp_valid_q |-> cal_busy_q)
        else $error("calibrate reply without busy");
    a_ctrl_echo: assert property (
        rsp_valid_q && rsp_code_q == `CCI_RSP_CTRL |-> rsp_data_q[7:0] == ctrl_q) else $error("ctrl reply wrong");
    a_unknown_err: assert property (
        $past(cmd_valid) && ($past(cmd_code) == 4'h0 || $past(cmd_code) > 4'h9) && rsp_valid_q
        |-> rsp_code_q == `CCI_RSP_UNKNOWN) else $error("unknown command not refused");
    a_busy_hold: assert property (
        $rose(cal_busy_q) |-> cal_busy_q [*8]) else $error("calibration too short");
    a_edge_start: assert property (
        rsp_valid_q && rsp_code_q == `CCI_RSP_CTRL && $rose(ctrl_q[1]) |=> cal_busy_q) else $error("start ignored");
    a_manual_quiet: assert property (
        $rose(cal_busy_q) && ctrl_q[0] |-> $past(cmd_valid) || $past(cmd_valid, 2)) else $error("auto run in manual");
    a_store_once: assert property (
        store_start_q |=> !store_start_q) else $error("store pulse too long");
    a_store_ok: assert property (
        store_start_q |-> ##[1:20] (rsp_valid_q && rsp_code_q == `CCI_RSP_OK)) else $error("store not acknowledged");
    a_restore_ban: assert property (
        load_defaults_q |-> ##[1:12] (rsp_valid_q && rsp_code_q == `CCI_RSP_BANNER)) else $error("no restore banner");
    a_boot_banner: assert property (
        $rose(rst_n) |-> ##[1:8] (rsp_valid_q && rsp_code_q == `CCI_RSP_BANNER)) else $error("no start-up banner");
    a_status_bit: assert property (
        rsp_valid_q && rsp_code_q == `CCI_RSP_STATUS |-> rsp_data_q[0] == $past(cal_busy_q)) else $error("status wrong");
    c_busy: cover property ($rose(cal_busy_q));
    c_unknown: cover property (rsp_valid_q && rsp_code_q == `CCI_RSP_UNKNOWN);
    c_restore: cover property (load_defaults_q);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind cci_core cci_props #(.VALUE_W(VALUE_W)) u_props (.clk, .rst_n, .cmd_valid, .cmd_code, .rsp_valid_q,
    .rsp_code_q, .rsp_data_q, .load_defaults_q, .store_start_q, .cal_busy_q, .ctrl_q);

/* verif/cci_host.sv */
// Host computer model: sends commands, collects replies
`include "cci_consts.vh"
module cci_host (
    // Clock
    input logic clk,
    // Command out
    output logic cmd_valid,
    output logic [3:0] cmd_code,
    output logic [7:0] cmd_data,
    // Reply in
    input logic rsp_valid_q,
    input logic [3:0] rsp_code_q,
    input logic [15:0] rsp_data_q,
    input logic cal_busy_q
);
    timeunit 1ns;
    timeprecision 1ns;
    logic timed_out = 1'h0;
    logic value_ok = 1'h0;
    logic [3:0] got_code;
    logic [15:0] got_data;
    initial
    begin
        cmd_valid = 1'h0;
        cmd_code = 4'h0;
        cmd_data = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Bounded wait for the next reply
    task automatic get_rsp(input int lim);
        got_code = `CCI_RSP_NONE;
        repeat (lim)
        begin
            // Reply may already stand when the command is released
            if (rsp_valid_q === 1'h1)
            begin
                got_code = rsp_code_q;
                got_data = rsp_data_q;
                value_ok = !cal_busy_q;
                return;
            end
            @(posedge clk);
            #1;
        end
        timed_out = 1'h1;
    endtask
    // One command, lines scrambled once released
    task automatic send(input logic [3:0] c, input logic [7:0] d);
        @(posedge clk);
        #1;
        cmd_valid = 1'h1;
        cmd_code = c;
        cmd_data = d;
        @(posedge clk);
        #1;
        cmd_valid = 1'h0;
        cmd_code = ~c;
        cmd_data = ~d;
        get_rsp(40);
    endtask
endmodule

/* verif/calibration_command_interpreter_tb_top.sv */
// Self-checking bench for the calibration command interpreter
`include "cci_consts.vh"
module calibration_command_interpreter_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [3:0] c; logic [7:0] d; logic [15:0] v; logic [3:0] rc; logic [15:0] rd;} cci_row_t;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic store_done = 1'h0;
    logic [3:0] rng = 4'h3;
    logic [2:0] chon = 3'h3;
    logic [15:0] v = 16'h0000;
    logic [15:0] lo = 16'h000A;
    logic [15:0] hi = 16'h0064;
    wire cmd_valid, rsp_valid_q, load_defaults_q, store_start_q, cal_busy_q;
    wire [3:0] cmd_code, rsp_code_q, keep_range_q;
    wire [7:0] cmd_data, ctrl_q;
    wire [15:0] rsp_data_q;
    int error_cnt = 0;
    int samples_checked = 0;
    int n;
    logic bad;
    cci_row_t rows [14] = '{
        '{4'h7, 8'h00, 16'h0032, `CCI_RSP_OK, 16'hFFFF}, '{4'h7, 8'h00, 16'h0009, `CCI_RSP_VALUE_LIMIT, 16'hFFFF},
        '{4'h7, 8'h00, 16'h0065, `CCI_RSP_VALUE_LIMIT, 16'hFFFF}, '{4'h7, 8'h04, 16'h0032, `CCI_RSP_VALUE_LIMIT, 16'hFFFF},
        '{4'h7, 8'h04, 16'h0033, `CCI_RSP_OK, 16'hFFFF}, '{4'h8, 8'h00, 16'h0032, `CCI_RSP_VALUE, 16'h0032},
        '{4'h8, 8'h02, 16'h0032, `CCI_RSP_CHANNEL_OFF, 16'hFFFF}, '{4'h8, 8'h03, 16'h0032, `CCI_RSP_CHANNEL_OFF, 16'hFFFF},
        '{4'h8, 8'h00, 16'h0009, `CCI_RSP_UNDERFLOW, 16'hFFFF}, '{4'h8, 8'h01, 16'h0065, `CCI_RSP_OVERFLOW, 16'hFFFF},
        '{4'h0, 8'h00, 16'h0000, `CCI_RSP_UNKNOWN, 16'hFFFF}, '{4'hF, 8'h00, 16'h0000, `CCI_RSP_UNKNOWN, 16'hFFFF},
        '{4'h5, 8'h00, 16'h0000, `CCI_RSP_CTRL, 16'h0001}, '{4'h9, 8'h00, 16'h0000, `CCI_RSP_STATUS, 16'h0000}};
    cci_core #(.CYC_PER_MIN(10), .BANNER_DELAY(5), .CAL_CYCLES(8)) u_dut (.clk, .rst_n, .cmd_valid, .cmd_code,
        .cmd_data, .param_value(v), .param_min(lo), .param_max(hi), .param_is_upper(cmd_data[2]),
        .param_pair_lower(16'h0032), .meas_channel(cmd_data[1:0]), .channel_on(chon), .meas_value(v),
        .meas_lo(lo), .meas_hi(hi), .work_range(rng), .store_done, .rsp_valid_q, .rsp_code_q, .rsp_data_q,
        .load_defaults_q, .keep_range_q, .store_start_q, .cal_busy_q, .ctrl_q);
    cci_host u_host (.clk, .cmd_valid, .cmd_code, .cmd_data, .rsp_valid_q, .rsp_code_q, .rsp_data_q, .cal_busy_q);
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #50 clk = ~clk;
    end
    // Storage finishes one cycle after each start
    always @(posedge clk) store_done <= #1 store_start_q;
    task automatic check_val(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic test_done;
        if (u_host.timed_out === 1'h1)
            error_cnt++;
        $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic cmd(input logic [3:0] c, input logic [7:0] d);
        u_host.send(c, d);
        if (u_host.timed_out === 1'h1)
            test_done();
    endtask
    // Cycles until the next calibration run starts
    task automatic time_run(output int k);
        k = 0;
        while (cal_busy_q === 1'h1 && k < 900) begin @(posedge clk); #1; k++; end
        while (cal_busy_q !== 1'h1 && k < 900) begin @(posedge clk); #1; k++; end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge clk);
        check_val("reset busy", 16'h0000, {15'h0000, cal_busy_q});
        check_val("reset ctrl", 16'h0000, {8'h00, ctrl_q});
        #1 rst_n = 1'h1;
        u_host.get_rsp(50);
        check_val("boot banner", `CCI_RSP_BANNER, u_host.got_code);
        check_val("release", 16'h0010, u_host.got_data);
        $display("Test boot done");
        for (int i = 0; i < 5; i++)
        begin
            time_run(n);
            check_val("auto spacing", 16'h0001, (n > ((i == 4) ? 585 : 130) && n < ((i == 4) ? 615 : 165)));
        end
        repeat (12) @(posedge clk);
        cmd(`CCI_CMD_CTRL_WRITE, 8'h01);
        check_val("ctrl write", 16'h0001, u_host.got_data);
        bad = 1'h0;
        repeat (700) begin @(posedge clk); #1; if (cal_busy_q !== 1'h0) bad = 1'h1; end
        check_val("manual quiet", 16'h0000, bad);
        $display("Test schedule done");
        foreach (rows[i])
        begin
            v = rows[i].v;
            cmd(rows[i].c, rows[i].d);
            check_val("reply code", rows[i].rc, u_host.got_code);
            if (rows[i].rd !== 16'hFFFF)
                check_val("reply data", rows[i].rd, u_host.got_data);
        end
        chon = 3'h7;
        v = 16'h0032;
        cmd(`CCI_CMD_MEAS_READ, 8'h02);
        check_val("channel on", `CCI_RSP_VALUE, u_host.got_code);
        $display("Test rows done");
        for (int i = 0; i < 3; i++)
        begin
            cmd(`CCI_CMD_CTRL_WRITE, (i == 1) ? 8'h03 : 8'h01);
            cmd(`CCI_CMD_CTRL_WRITE, 8'h03);
            @(posedge clk);
            #1;
            check_val("start edge", (i == 1) ? 16'h0000 : 16'h0001, cal_busy_q);
            repeat (12) @(posedge clk);
        end
        cmd(`CCI_CMD_CALIBRATE_NOW, 8'h00);
        check_val("calibrate ok", `CCI_RSP_OK, u_host.got_code);
        check_val("calibrate busy", 16'h0001, cal_busy_q);
        cmd(`CCI_CMD_STATUS_READ, 8'h00);
        check_val("status busy", 16'h0001, u_host.got_data);
        check_val("value invalid", 16'h0000, {15'h0000, u_host.value_ok});
        $display("Test calibration done");
        cmd(`CCI_CMD_STORE_CONFIG, 8'h00);
        check_val("store ok", `CCI_RSP_OK, u_host.got_code);
        rng = 4'h5;
        cmd(`CCI_CMD_FACTORY_RESTORE, 8'h00);
        check_val("restore banner", `CCI_RSP_BANNER, u_host.got_code);
        check_val("range kept", 16'h0005, keep_range_q);
        cmd(`CCI_CMD_RESTART, 8'h00);
        check_val("restart banner", `CCI_RSP_BANNER, u_host.got_code);
        $display("Test actions done");
        test_done();
    end
endmodule
